// ### rtl/rfp_comma_match.sv
// Framing character matcher on one 10-bit window, oldest bit in the MSB.
// Assumes the window is taken from the same clock as the select.
`include "rfp_regs.svh"
module rfp_comma_match
  import rfp_pkg::*;
(
  input  wire logic [9:0] win,
  input  rfp_lvl_t        sel,
  output logic            hit
);
  always_comb
  begin
    hit = 1'b0;
    unique case (sel)
      LVL_MID:  hit = (win[9:2] == `RFP_COMMA_NEG) || (win[9:2] == `RFP_COMMA_POS);
      LVL_HIGH: hit = (win == `RFP_K285_NEG) || (win == `RFP_K285_POS);
      // Test-only setting never frames
      LVL_LOW:  hit = 1'b0;
      default:  hit = 1'b0;
    endcase
  end
endmodule : rfp_comma_match

// ### rtl/rfp_framer_ctl.sv
// Receive framer, parity check and generate, and receive elasticity buffer.
// Assumes clk is the reference clock, the tx port is synchronous to it,
// and the recovered bit stream arrives as data plus a toggle per bit.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`include "rfp_regs.svh"

module rfp_framer_ctl
  import rfp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        reframe_allow,
  input  wire logic        serialBit,
  input  wire logic        serialToggle,
  input  wire logic        txValid,
  input  rfp_tx_t          txIn,
  output logic             rxValid,
  output rfp_rx_t          rxOut,
  output logic             rxParityOut,
  output logic             rxParityOeN
);
  rfp_state_t s;
  rfp_state_t next_s;

  logic        bitStb;
  logic [19:0] shNext;
  logic        winHit;
  logic [3:0]  phase;
  logic        emitLow;
  logic [9:0]  emitChar;
  logic        emitFrame;
  logic        chStb;
  logic        realign;
  logic        pairOk;
  logic [2:0]  runNext;
  logic        bypass;
  logic [10:0] txMask;
  logic [10:0] rxMask;
  logic        txOdd;
  logic        txErr;
  logic        refTick;
  logic        ebOn;
  logic        ebWr;
  logic        ebRd;
  logic        ovfl;
  logic        unfl;
  logic        outStb;
  logic [10:0] outChar;
  logic        insEvt;
  rfp_rx_t     rxNext;
  logic        rxOdd;
  logic        aAcc;
  logic [3:0]  statClr;

  rfp_comma_match u_win_match
  (
    .win (shNext[9:0]),
    .sel (s.ctrl.charSel),
    .hit (winHit)
  );

  rfp_comma_match u_emit_match
  (
    .win (emitChar),
    .sel (s.ctrl.charSel),
    .hit (emitFrame)
  );

  rfp_odd_parity u_tx_par
  (
    .data ({1'b0, txIn.ctl, txIn.data}),
    .mask (txMask),
    .odd  (txOdd)
  );

  rfp_odd_parity u_rx_par
  (
    .data ({rxNext.status, rxNext.data}),
    .mask (rxMask),
    .odd  (rxOdd)
  );

  always_comb
  begin
    next_s  = s;
    bitStb  = s.syncTog[2] ^ s.syncTog[1];
    shNext  = {s.sr[18:0], s.syncBit[1]};
    phase   = 4'd9 - s.bitCnt;
    emitLow = 1'b0;
    chStb   = 1'b0;
    realign = 1'b0;
    pairOk  = 1'b0;
    runNext = 3'd1;
    txErr   = 1'b0;
    ebWr    = 1'b0;
    ebRd    = 1'b0;
    ovfl    = 1'b0;
    unfl    = 1'b0;
    outStb  = 1'b0;
    outChar = '0;
    insEvt  = 1'b0;
    statClr = '0;
    rxNext  = s.rx;

    // Pin synchronisers
    next_s.syncTog   = {s.syncTog[1:0], serialToggle};
    next_s.syncBit   = {s.syncBit[0], serialBit};
    next_s.syncAllow = {s.syncAllow[0], reframe_allow};

    // Framer on each recovered bit
    if (bitStb)
    begin
      next_s.sr     = shNext;
      next_s.bitCnt = (s.bitCnt == 4'd9) ? 4'd0 : s.bitCnt + 4'd1;
      chStb = (s.bitCnt == 4'd9);
      if (s.candAge != 7'h7f)
        next_s.candAge = s.candAge + 7'd1;
      if (winHit && s.syncAllow[1])
      begin
        next_s.candPh  = phase;
        next_s.candAge = '0;
        next_s.candOk  = 1'b1;
        unique case (s.ctrl.frameMode)
          LVL_LOW:
          begin
            emitLow       = 1'b1;
            chStb         = 1'b1;
            next_s.bitCnt = 4'd0;
            next_s.off    = 4'd0;
            realign       = (s.off != 4'd0) || (s.bitCnt != 4'd9);
          end
          LVL_MID:
          begin
            // pair within span
            // Widened sum so a saturated age cannot wrap into range
            pairOk = s.candOk && (phase == s.candPh)
                     && (8'(s.candAge) + 8'd1 + 8'(`RFP_CHAR_BITS) <= 8'(`RFP_PAIR_SPAN));
            if (pairOk)
            begin
              next_s.off = phase;
              realign    = (phase != s.off);
            end
          end
          LVL_HIGH:
          begin
            if (s.candOk && (phase == s.candPh) && (s.candAge == `RFP_ADJ_AGE))
              runNext = (s.run == `RFP_RUN_LEN) ? s.run : s.run + 3'd1;
            next_s.run = runNext;
            if (runNext == `RFP_RUN_LEN)
            begin
              next_s.off = phase;
              realign    = (phase != s.off);
            end
          end
          default:
          begin
            realign = 1'b0;
          end
        endcase
      end
    end
    emitChar = emitLow ? shNext[9:0] : shNext[s.off +: 10];

    // Parity masks per coding state
    bypass = (s.ctrl.txOpSel == LVL_LOW) && (s.ctrl.decSel == LVL_LOW);
    if (s.ctrl.parity_control == LVL_HIGH)
    begin
      txMask = `RFP_MASK_BC2;
      rxMask = `RFP_MASK_BC3;
    end
    else if (bypass)
    begin
      txMask = `RFP_MASK_BC2;
      rxMask = `RFP_MASK_BC2;
    end
    else
    begin
      txMask = `RFP_MASK_BYTE;
      rxMask = `RFP_MASK_BYTE;
    end

    // tx port sampled on reference clock
    if (txValid && (s.ctrl.parity_control != LVL_LOW))
      txErr = (txIn.par != txOdd);

    // Reference rate character tick
    refTick    = (s.div == 5'd0);
    next_s.div = refTick ? `RFP_REF_DIV - 5'd1 : s.div - 5'd1;

    ebOn = (s.ctrl.rxClkSel == 1'b0);
    if (ebOn)
    begin
      if (chStb)
      begin
        if ((s.fill >= `RFP_EB_HI) && emitFrame)
          next_s.dropCnt = s.dropCnt + 16'd1;
        else if (s.fill == `RFP_EB_DEPTH)
          ovfl = 1'b1;
        else
          ebWr = 1'b1;
      end
      if (refTick)
      begin
        if (s.pendIns)
        begin
          outStb         = 1'b1;
          outChar        = {1'b1, `RFP_K285_NEG};
          insEvt         = 1'b1;
          next_s.pendIns = 1'b0;
          next_s.insCnt  = s.insCnt + 16'd1;
        end
        else if (s.fill != 4'd0)
        begin
          ebRd    = 1'b1;
          outStb  = 1'b1;
          outChar = s.mem[s.rp];
          if ((s.fill <= `RFP_EB_LO) && s.mem[s.rp][10])
            next_s.pendIns = 1'b1;
        end
        else
          unfl = 1'b1;
      end
      if (ebWr)
      begin
        next_s.mem[s.wp] = {emitFrame, emitChar};
        next_s.wp        = s.wp + 3'd1;
      end
      if (ebRd)
        next_s.rp = s.rp + 3'd1;
      next_s.fill = s.fill + {3'd0, ebWr} - {3'd0, ebRd};
    end
    else
    begin
      outStb         = chStb;
      outChar        = {emitFrame, emitChar};
      next_s.wp      = '0;
      next_s.rp      = '0;
      next_s.fill    = '0;
      next_s.pendIns = 1'b0;
    end

    // Receive output stage
    if (outStb)
    begin
      rxNext.data = outChar[7:0];
      if (bypass)
        rxNext.status = {1'b0, outChar[9:8]};
      else
        rxNext.status = {insEvt, 1'b0, outChar[10]};
    end
    next_s.rxValid = outStb;
    next_s.rx      = rxNext;
    if (outStb)
      next_s.rxPar = rxOdd;
    next_s.rxOeN = (s.ctrl.parity_control == LVL_LOW);

    // AHB-Lite address phase
    aAcc         = hsel && htrans[1] && hready;
    next_s.aWr   = aAcc && hwrite;
    next_s.aAddr = haddr[7:0];
    if (aAcc && !hwrite)
    begin
      unique case (haddr[7:0])
        `RFP_CTRL_OFS: next_s.rdata = {20'h0, s.ctrl};
        `RFP_STAT_OFS: next_s.rdata = {24'h0, s.off, s.stat};
        `RFP_CNT_OFS:  next_s.rdata = {s.dropCnt, s.insCnt};
        default:       next_s.rdata = 32'h0;
      endcase
    end

    // AHB-Lite write data phase
    if (s.aWr)
    begin
      if (s.aAddr == `RFP_CTRL_OFS)
        next_s.ctrl = rfp_ctrl_t'(hwdata[`RFP_CTRL_W-1:0]);
      if (s.aAddr == `RFP_STAT_OFS)
        statClr = hwdata[`RFP_STAT_CLRW-1:0];
    end

    // Sticky flags, set wins over clear
    next_s.stat = (s.stat & ~statClr) | {unfl, ovfl, realign, txErr};
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s       <= '0;
      s.ctrl  <= rfp_ctrl_t'(`RFP_CTRL_RST);
      s.rxOeN <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign hrdata      = s.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign rxValid     = s.rxValid;
  assign rxOut       = s.rx;
  assign rxParityOut = s.rxPar;
  assign rxParityOeN = s.rxOeN;
endmodule : rfp_framer_ctl

// ### rtl/rfp_odd_parity.sv
// Odd parity over the bits of a word selected by a mask.
// Assumes mask bits above the used field are zero.
module rfp_odd_parity
(
  input  wire logic [10:0] data,
  input  wire logic [10:0] mask,
  output logic             odd
);
  assign odd = ~^(data & mask);
endmodule : rfp_odd_parity

// ### rtl/rfp_pkg.sv
// Types shared by the framer control block and its helpers.
// Assumes rfp_regs.svh supplies all numeric constants.
package rfp_pkg;
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} rfp_lvl_t;

  typedef struct packed {
    rfp_lvl_t txOpSel;
    logic     rxClkSel;
    logic     txClkSel;
    rfp_lvl_t decSel;
    rfp_lvl_t parity_control;
    rfp_lvl_t charSel;
    rfp_lvl_t frameMode;
  } rfp_ctrl_t;

  typedef struct packed {
    logic [1:0] ctl;
    logic [7:0] data;
    logic       par;
  } rfp_tx_t;

  typedef struct packed {
    logic [2:0] status;
    logic [7:0] data;
  } rfp_rx_t;

  typedef struct packed {
    rfp_ctrl_t       ctrl;
    logic [3:0]      stat;
    logic [15:0]     insCnt;
    logic [15:0]     dropCnt;
    logic            aWr;
    logic [7:0]      aAddr;
    logic [31:0]     rdata;
    logic [2:0]      syncTog;
    logic [1:0]      syncBit;
    logic [1:0]      syncAllow;
    logic [19:0]     sr;
    logic [3:0]      bitCnt;
    logic [3:0]      off;
    logic [3:0]      candPh;
    logic [6:0]      candAge;
    logic [2:0]      run;
    logic            candOk;
    logic [7:0][10:0] mem;
    logic [2:0]      wp;
    logic [2:0]      rp;
    logic [3:0]      fill;
    logic [4:0]      div;
    logic            pendIns;
    logic            rxValid;
    rfp_rx_t         rx;
    logic            rxPar;
    logic            rxOeN;
  } rfp_state_t;
endpackage : rfp_pkg

// ### rtl/rfp_regs.svh
// Offsets, field positions, reset values and counts of the framer control block.
// Assumes a byte-addressed AHB-Lite slave window of 256 bytes.
`ifndef RFP_REGS_SVH
`define RFP_REGS_SVH
`define RFP_CTRL_OFS     8'h00
`define RFP_STAT_OFS     8'h04
`define RFP_CNT_OFS      8'h08
`define RFP_CTRL_RST     12'h849
`define RFP_CTRL_W       12
`define RFP_STAT_TXPAR   0
`define RFP_STAT_REALIGN 1
`define RFP_STAT_OVFL    2
`define RFP_STAT_UNFL    3
`define RFP_STAT_CLRW    4
`define RFP_K285_NEG     10'h0fa
`define RFP_K285_POS     10'h305
`define RFP_COMMA_NEG    8'h3e
`define RFP_COMMA_POS    8'hc1
`define RFP_PAIR_SPAN    7'd50
`define RFP_CHAR_BITS    7'd10
`define RFP_ADJ_AGE      7'd9
`define RFP_RUN_LEN      3'd4
`define RFP_REF_DIV      5'd20
`define RFP_EB_DEPTH     4'd8
`define RFP_EB_HI        4'd6
`define RFP_EB_LO        4'd2
`define RFP_MASK_BYTE    11'h0ff
`define RFP_MASK_BC2     11'h3ff
`define RFP_MASK_BC3     11'h7ff
`endif

// ### tb/rfp_framer_ctl_bench.sv
// Self-checking bench of the framer control block with a serial source.
// Assumes one 200 MHz clock and the checker bound from its own file.
`include "rfp_regs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module rfp_framer_ctl_bench
  import rfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] Kc = `RFP_K285_NEG;
  localparam logic [9:0] Comma = 10'h0f9;
  localparam logic [9:0] Fill = 10'h155;
  logic        clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, txValid = 1'b0;
  logic        reframeAllow = 1'b1, rxValid, hreadyout, hresp, rxParityOut, rxParityOeN;
  logic        serialBit, serialToggle, charLoad;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rnd = 32'h92344575;
  logic [9:0]  nextChar = Fill;
  logic [3:0]  slipBits = 4'd0, s;
  rfp_tx_t     txIn = '0;
  rfp_rx_t     rxOut;
  rfp_ctrl_t   c;
  int          miscompares = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  rfp_framer_ctl dut_u
  (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reframe_allow(reframeAllow), .serialBit(serialBit),
    .serialToggle(serialToggle), .txValid(txValid), .txIn(txIn), .rxValid(rxValid),
    .rxOut(rxOut), .rxParityOut(rxParityOut), .rxParityOeN(rxParityOeN)
  );
  rfp_serial_src src_u
  (
    .clk(clk), .sys_rst(sys_rst), .nextChar(nextChar), .slipBits(slipBits),
    .serialBit(serialBit), .serialToggle(serialToggle), .charLoad(charLoad)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic txErr(input rfp_ctrl_t k, input rfp_tx_t t);
    if (k.parity_control == LVL_LOW)
      return 1'b0;
    if (k.parity_control == LVL_MID && (k.txOpSel != LVL_LOW || k.decSel != LVL_LOW))
      return ~(^t.data ^ t.par);
    return ~(^{t.ctl, t.data} ^ t.par);
  endfunction : txErr
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  // char select never low, tx on reference clock
  task automatic setc(input rfp_lvl_t m, input rfp_lvl_t ch, input rfp_lvl_t p,
                      input logic byp, input logic rxs);
    c = '{txOpSel: byp ? LVL_LOW : LVL_HIGH, rxClkSel: rxs, txClkSel: 1'b0,
          decSel: byp ? LVL_LOW : LVL_MID, parity_control: p, charSel: ch, frameMode: m};
    bus(1'b1, `RFP_CTRL_OFS, {20'h0, c}, rd);
    bus(1'b1, `RFP_STAT_OFS, 32'hf, rd);
  endtask : setc
  task automatic burst(input logic [9:0] ch, input int n, input logic [3:0] sl);
    for (int i = 0; i < n; i++)
    begin
      nextChar <= (i % 2) ? ~ch : ch;
      slipBits <= (i == 0) ? sl : 4'd0;
      do @(posedge clk); while (charLoad !== 1'b1);
    end
    nextChar <= Fill;
    slipBits <= 4'd0;
    do @(posedge clk); while (charLoad !== 1'b1);
  endtask : burst
  task automatic realign(input logic e);
    repeat (8) @(posedge clk);
    bus(1'b0, `RFP_STAT_OFS, 32'h0, rd);
    `CHK("realign flag", e, rd[`RFP_STAT_REALIGN])
    bus(1'b1, `RFP_STAT_OFS, 32'hf, rd);
  endtask : realign
  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, `RFP_CTRL_OFS, 32'h0, rd);
    `CHK("ctrl reset", {20'h0, `RFP_CTRL_RST}, rd)
    bus(1'b1, `RFP_CNT_OFS, 32'hffffffff, rd);
    bus(1'b0, `RFP_CNT_OFS, 32'h0, rd);
    `CHK("counts", 32'h0, rd)
    bus(1'b0, 8'h0c, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    repeat (12)
    begin
      rnd = lfsr(rnd);
      setc(LVL_MID, LVL_HIGH, rfp_lvl_t'(rnd[1:0] % 3), rnd[2], 1'b1);
      txIn    <= rnd[20:10];
      txValid <= 1'b1;
      @(posedge clk);
      txValid <= 1'b0;
      bus(1'b0, `RFP_STAT_OFS, 32'h0, rd);
      `CHK("tx parity", txErr(c, rnd[20:10]), rd[`RFP_STAT_TXPAR])
    end
    s = {2'b0, rnd[1:0]} + 4'd1;
    setc(LVL_HIGH, LVL_HIGH, LVL_HIGH, 1'b0, 1'b1);
    burst(Kc, 3, s);
    realign(1'b0);
    burst(Kc, 4, s);
    realign(1'b1);
    reframeAllow <= 1'b0;
    burst(Kc, 5, s);
    realign(1'b0);
    reframeAllow <= 1'b1;
    setc(LVL_MID, LVL_MID, LVL_MID, 1'b1, 1'b1);
    burst(Comma, 2, s);
    realign(1'b1);
    setc(LVL_MID, LVL_HIGH, LVL_HIGH, 1'b1, 1'b1);
    burst(Comma, 4, s);
    realign(1'b0);
    burst(Kc, 1, s);
    burst(Fill, 4, 4'd0);
    burst(Kc, 1, 4'd0);
    realign(1'b0);
    setc(LVL_LOW, LVL_HIGH, LVL_LOW, 1'b0, 1'b1);
    burst(Kc, 1, s);
    realign(1'b1);
    setc(LVL_HIGH, LVL_HIGH, LVL_HIGH, 1'b0, 1'b0);
    burst(Kc, 12, 4'd0);
    bus(1'b0, `RFP_CNT_OFS, 32'h0, rd);
    `CHK("inserted", 1'b1, rd[15:0] != 16'h0)
    `CHK("dropped", 16'h0, rd[31:16])
    tally_and_finish();
  end
endmodule : rfp_framer_ctl_bench

// ### tb/rfp_framer_ctl_sva.sv
// Port checker of the framer control block.
// Assumes CTRL changes only through the watched bus port.
`include "rfp_regs.svh"
module rfp_framer_ctl_sva
  import rfp_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        rxValid,
  input rfp_rx_t          rxOut,
  input wire logic        rxParityOut,
  input wire logic        rxParityOeN
);
  localparam int CharClk = 40;
  localparam int TickClk = 20;
  logic [11:0] ctrl;
  logic        aWr;
  logic        aWrLag;
  logic        seen;
  logic [15:0] gap;
  logic [1:0]  par;
  logic        byp;
  assign par = ctrl[5:4];
  assign byp = ctrl[11:10] == 2'd0 && ctrl[7:6] == 2'd0;
  // Shadow of CTRL and spacing of rx strobes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl <= `RFP_CTRL_RST;
      aWr  <= 1'b0;
      aWrLag <= 1'b0;
      seen <= 1'b0;
      gap  <= 16'd0;
    end
    else
    begin
      aWr  <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == `RFP_CTRL_OFS;
      if (aWr)
        ctrl <= hwdata[11:0];
      aWrLag <= aWr;
      // Strobe launched on the CTRL write edge still follows the old mode
      seen <= !aWr && !aWrLag && (seen || rxValid);
      gap  <= rxValid ? 16'd1 : gap + 16'd1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_OE_OFF: assert property (ctrl == $past(ctrl) && par == 2'd0 |-> rxParityOeN)
    else $error("parity pin driven while parity off");
  AST_OE_ON: assert property (ctrl == $past(ctrl) && par != 2'd0 |-> !rxParityOeN)
    else $error("parity pin floating while parity on");
  AST_PAR_BYTE: assert property (rxValid && ctrl == $past(ctrl) && par == 2'd1 && !byp
    |-> rxParityOut == ~^rxOut.data) else $error("byte parity wrong");
  AST_PAR_BYP: assert property (rxValid && ctrl == $past(ctrl) && par == 2'd1 && byp
    |-> rxParityOut == ~^{rxOut.status[1:0], rxOut.data}) else $error("bypass parity wrong");
  AST_PAR_ALL: assert property (rxValid && ctrl == $past(ctrl) && par == 2'd2
    |-> rxParityOut == ~^{rxOut.status, rxOut.data}) else $error("full parity wrong");
  AST_CADENCE: assert property (rxValid && seen && ctrl[9] && ctrl[1:0] != 2'd0
    && ctrl[1:0] != 2'd3 |-> gap == CharClk) else $error("char strobe cadence moved");
  AST_REF_TICK: assert property (rxValid && seen && !ctrl[9] |-> gap % TickClk == 0)
    else $error("buffered output off reference tick");
  AST_INSERT: assert property (rxValid && rxOut.status[2] && !byp |-> rxOut.status[0]
    && (rxOut.data == 8'hfa || rxOut.data == 8'h05)) else $error("added char not K28.5");
endmodule : rfp_framer_ctl_sva
bind rfp_framer_ctl rfp_framer_ctl_sva chk_u
(
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .rxValid(rxValid), .rxOut(rxOut),
  .rxParityOut(rxParityOut), .rxParityOeN(rxParityOeN)
);

// ### tb/rfp_serial_src.sv
// Recovered serial stream source: one bit every BitClk clocks, MSB first.
// Assumes a continuous line; nextChar and slipBits are taken at charLoad.
module rfp_serial_src
#(
  parameter int BitClk = 4
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [9:0] nextChar,
  input  wire logic [3:0] slipBits,
  output logic            serialBit,
  output logic            serialToggle,
  output logic            charLoad
);
  logic [19:0] sh;
  logic [4:0]  left;
  logic [7:0]  div;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sh           <= 20'h0;
      left         <= 5'd0;
      div          <= 8'd0;
      serialBit    <= 1'b0;
      serialToggle <= 1'b0;
      charLoad     <= 1'b0;
    end
    else
    begin
      charLoad <= 1'b0;
      div      <= (div == 8'(BitClk - 1)) ? 8'd0 : div + 8'd1;
      // Toggle mid-bit so data is settled first
      if (div == 8'(BitClk / 2))
        serialToggle <= ~serialToggle;
      if (div == 8'd0 && left == 5'd0)
      begin
        serialBit <= slipBits == 4'd0 ? nextChar[9] : 1'b0;
        sh        <= ({10'h0, nextChar} << (5'd10 - {1'b0, slipBits})) << 1;
        left      <= 5'd9 + {1'b0, slipBits};
        charLoad  <= 1'b1;
      end
      else if (div == 8'd0)
      begin
        serialBit <= sh[19];
        sh        <= sh << 1;
        left      <= left - 5'd1;
      end
    end
  end
endmodule : rfp_serial_src
